// ### rtl/spm_pin_sync.sv
// two-stage synchronisers and edge detectors for the serial pins
`timescale 1ns/10ps
module spm_pin_sync (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  // raw pins
  input  wire logic [spm_pkg::PIN_COUNT-1:0] pin_in,
  // synchronised levels and edges
  output logic      [spm_pkg::PIN_COUNT-1:0] level_out,
  output logic      [spm_pkg::PIN_COUNT-1:0] rise_out,
  output logic      [spm_pkg::PIN_COUNT-1:0] fall_out
);
  import spm_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++)
    begin : g_pin
      logic meta;
      logic stable;
      logic last;
      // first stage feeds only the second
      always_ff @(posedge clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          meta   <= 1'b0;
          stable <= 1'b0;
          last   <= 1'b0;
        end
        else
        begin
          meta   <= pin_in[i];
          stable <= meta;
          last   <= stable;
        end
      end
      assign level_out[i] = stable;
      assign rise_out[i]  = stable & ~last;
      assign fall_out[i]  = ~stable & last;
    end
  endgenerate

endmodule // spm_pin_sync

// ### rtl/spm_pkg.sv
// constants, register map and types of the serial port block
package spm_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  CTRL_INDEX   = 8'hD2;
  localparam logic [7:0]  DATA_INDEX   = 8'hD3;
  localparam logic [7:0]  STATUS_INDEX = 8'hD4;
  localparam logic [7:0]  AUX_INDEX    = 8'hD5;
  localparam logic [31:0] CTRL_ADDR    = {22'h000000, CTRL_INDEX, 2'h0};
  localparam logic [31:0] DATA_ADDR    = {22'h000000, DATA_INDEX, 2'h0};
  localparam logic [31:0] STATUS_ADDR  = {22'h000000, STATUS_INDEX, 2'h0};
  localparam logic [31:0] AUX_ADDR     = {22'h000000, AUX_INDEX, 2'h0};

  // reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] AUX_RESET    = 3'h0;

  // serial_port_control fields
  localparam int CTRL_PORT_ENABLE = 7;
  localparam int CTRL_LOW_FIRST   = 6;
  localparam int CTRL_MASTER      = 5;
  localparam int CTRL_CPOL        = 4;
  localparam int CTRL_CPHA        = 3;
  localparam int CTRL_DOUBLER     = 2;
  localparam int CTRL_RATE_HI     = 1;
  localparam int CTRL_RATE_LO     = 0;

  // serial_port_status fields
  localparam int STAT_DONE      = 7;
  localparam int STAT_COLLISION = 6;
  localparam int STAT_SS_HIGH   = 5;
  localparam int STAT_TWO_PIN   = 3;
  localparam int STAT_SS_ENABLE = 2;
  localparam int STAT_TX_ENABLE = 1;
  localparam int STAT_RX_ENABLE = 0;

  // auxiliary register fields
  localparam int AUX_IRQ_ENABLE = 0;
  localparam int AUX_SS_DIR     = 1;
  localparam int AUX_SS_OUT     = 2;

  // sck half periods in core cycles, indexed by doubler and rate select
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_DIV2   = 7'h01;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV32  = 7'h10;

  // index of the last sck edge in one byte, counted from zero
  localparam logic [4:0] LAST_EDGE = 5'h0F;

  // synchronised pins
  localparam int PIN_COUNT = 4;
  localparam int PIN_SS    = 3;
  localparam int PIN_SCK   = 2;
  localparam int PIN_MOSI  = 1;
  localparam int PIN_MISO  = 0;

  typedef enum logic [0:0] {
    SPM_IDLE  = 1'b0,
    SPM_SHIFT = 1'b1
  } spm_state_type;

endpackage

// ### rtl/spm_port.sv
// serial port engine with ahb-lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
module spm_port (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic      [31:0] hrdata_out,
  // interrupt handshake
  input  wire logic        irq_service_in,
  output logic             irq_request_out,
  // serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  // master out pin
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_out,
  // master in pin
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  // select pin
  input  wire logic        ss_in,
  output logic             ss_out,
  output logic             ss_oe_out
);
  import spm_pkg::*;

  logic                 rst_meta;
  logic                 rstn_sync;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;
  logic [7:0]           ctrl;
  logic [2:0]           aux;
  logic                 done_flag;
  logic                 collision_flag;
  logic                 ss_high_flag;
  logic                 two_pin;
  logic                 ss_enable;
  logic                 tx_enable;
  logic                 rx_enable;
  logic                 status_seen;
  logic                 wr_pending;
  logic [31:0]          wr_addr;
  logic [7:0]           rx_data;
  logic [7:0]           tx_hold;
  logic [7:0]           shift_reg;
  logic [7:0]           next_shift;
  logic                 out_bit;
  logic                 sck_level;
  logic [6:0]           div_cnt;
  logic [6:0]           half_period;
  logic [4:0]           edge_cnt;
  spm_state_type        state;
  logic                 bus_take;
  logic                 rd_take;
  logic                 status_read;
  logic                 data_read;
  logic                 wr_ctrl;
  logic                 wr_data;
  logic                 wr_status;
  logic                 wr_aux;
  logic                 data_access;
  logic [7:0]           read_value;
  logic                 port_enable;
  logic                 master;
  logic                 low_first;
  logic                 cpol;
  logic                 cpha;
  logic                 irq_enable;
  logic                 ss_pin_input;
  logic                 ss_internal;
  logic                 mode_fault;
  logic                 slave_selected;
  logic                 tick;
  logic                 edge_evt;
  logic                 leading;
  logic                 sample_evt;
  logic                 setup_evt;
  logic                 in_bit;
  logic                 done_evt;
  logic                 start;
  logic [1:0]           samp_dly;
  logic [1:0]           done_dly;
  logic [7:0]           rx_shift;
  logic [7:0]           next_rx;
  logic                 cap_evt;
  logic                 fin_evt;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta  <= 1'b0;
      rstn_sync <= 1'b0;
    end
    else
    begin
      rst_meta  <= 1'b1;
      rstn_sync <= rst_meta;
    end
  end

  spm_pin_sync u_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_sync),
    .pin_in    ({ss_in, sck_in, mosi_in, miso_in}),
    .level_out (pin_level),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  assign port_enable = ctrl[CTRL_PORT_ENABLE];
  assign master      = ctrl[CTRL_MASTER];
  assign low_first   = ctrl[CTRL_LOW_FIRST];
  assign cpol        = ctrl[CTRL_CPOL];
  assign cpha        = ctrl[CTRL_CPHA];
  assign irq_enable  = aux[AUX_IRQ_ENABLE];

  // bus decode; reads act in the address phase, writes in the data phase
  assign bus_take    = hsel_in & htrans_in[1] & hready_in;
  assign rd_take     = bus_take & ~hwrite_in;
  assign status_read = rd_take & (haddr_in == STATUS_ADDR);
  assign data_read   = rd_take & (haddr_in == DATA_ADDR);
  assign wr_ctrl     = wr_pending & (wr_addr == CTRL_ADDR);
  assign wr_data     = wr_pending & (wr_addr == DATA_ADDR);
  assign wr_status   = wr_pending & (wr_addr == STATUS_ADDR);
  assign wr_aux      = wr_pending & (wr_addr == AUX_ADDR);
  assign data_access = data_read | wr_data;

  always_comb
  begin
    read_value = 8'h00;
    unique case (haddr_in)
      CTRL_ADDR:   read_value = ctrl;
      DATA_ADDR:   read_value = rx_data;
      STATUS_ADDR: read_value = {done_flag, collision_flag, ss_high_flag, 1'b0,
                                 two_pin, ss_enable, tx_enable, rx_enable};
      AUX_ADDR:    read_value = {5'h00, aux};
      default:     read_value = 8'h00;
    endcase
  end

  // zero wait states, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
    begin
      wr_pending <= 1'b0;
      wr_addr    <= 32'h00000000;
      hrdata_out <= 32'h00000000;
    end
    else
    begin
      wr_pending <= bus_take & hwrite_in;
      if (bus_take)
        wr_addr <= haddr_in;
      if (rd_take)
        hrdata_out <= {24'h000000, read_value};
      else
        hrdata_out <= 32'h00000000;
    end
  end

  // select pin handling
  assign ss_pin_input   = ss_enable & (~master | ~aux[AUX_SS_DIR]);
  assign ss_internal    = ss_enable ? pin_level[PIN_SS] : master;
  assign mode_fault     = port_enable & master & ss_pin_input & ~pin_level[PIN_SS];
  assign slave_selected = ~master & ~ss_internal;

  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      ctrl <= CTRL_RESET;
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata_in[7:0];
      if (mode_fault)
        ctrl[CTRL_MASTER] <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      aux <= AUX_RESET;
    else if (wr_aux)
      aux <= hwdata_in[2:0];
  end

  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
    begin
      two_pin   <= STATUS_RESET[STAT_TWO_PIN];
      ss_enable <= STATUS_RESET[STAT_SS_ENABLE];
      tx_enable <= STATUS_RESET[STAT_TX_ENABLE];
      rx_enable <= STATUS_RESET[STAT_RX_ENABLE];
    end
    else if (wr_status)
    begin
      two_pin   <= hwdata_in[STAT_TWO_PIN];
      ss_enable <= hwdata_in[STAT_SS_ENABLE];
      tx_enable <= hwdata_in[STAT_TX_ENABLE];
      rx_enable <= hwdata_in[STAT_RX_ENABLE];
    end
  end

  // rising select edge; a set in the clearing cycle wins
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      ss_high_flag <= STATUS_RESET[STAT_SS_HIGH];
    else if (ss_pin_input & pin_rise[PIN_SS])
      ss_high_flag <= 1'b1;
    else if (wr_status & ~hwdata_in[STAT_SS_HIGH])
      ss_high_flag <= 1'b0;
  end

  // sck divider selection
  always_comb
  begin
    half_period = HALF_DIV4;
    unique case ({ctrl[CTRL_DOUBLER], ctrl[CTRL_RATE_HI], ctrl[CTRL_RATE_LO]})
      3'h0: half_period = HALF_DIV4;
      3'h1: half_period = HALF_DIV16;
      3'h2: half_period = HALF_DIV64;
      3'h3: half_period = HALF_DIV128;
      3'h4: half_period = HALF_DIV2;
      3'h5: half_period = HALF_DIV8;
      3'h6: half_period = HALF_DIV32;
      3'h7: half_period = HALF_DIV64;
    endcase
  end

  // edge events, shared by both roles
  assign tick       = (div_cnt == half_period - 7'h01);
  assign edge_evt   = (state == SPM_SHIFT) &
                      (master ? tick : slave_selected & (pin_rise[PIN_SCK] | pin_fall[PIN_SCK]));
  assign leading    = master ? (sck_level == cpol) : (pin_rise[PIN_SCK] ? ~cpol : cpol);
  assign sample_evt = edge_evt & (leading ^ cpha);
  assign setup_evt  = edge_evt & ~(leading ^ cpha);
  assign in_bit     = master ? pin_level[PIN_MISO] : pin_level[PIN_MOSI];
  assign next_shift = low_first ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
  assign done_evt   = edge_evt & (edge_cnt == LAST_EDGE);
  assign start      = wr_data & port_enable & (state == SPM_IDLE);
  // master capture waits out the miso synchroniser; slave pins share its delay
  assign cap_evt    = master ? samp_dly[1] : sample_evt;
  assign fin_evt    = master ? done_dly[1] : done_evt;
  assign next_rx    = low_first ? {in_bit, rx_shift[7:1]} : {rx_shift[6:0], in_bit};

  // transfer sequencer
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
    begin
      state     <= SPM_IDLE;
      edge_cnt  <= 5'h00;
      shift_reg <= DATA_RESET;
      tx_hold   <= DATA_RESET;
      out_bit   <= 1'b0;
    end
    else if (!port_enable | mode_fault)
    begin
      state    <= SPM_IDLE;
      edge_cnt <= 5'h00;
    end
    else if (start)
    begin
      state     <= SPM_SHIFT;
      edge_cnt  <= 5'h00;
      shift_reg <= hwdata_in[7:0];
      tx_hold   <= hwdata_in[7:0];
      out_bit   <= low_first ? hwdata_in[0] : hwdata_in[7];
    end
    else if ((state == SPM_SHIFT) & ~master & ss_internal)
    begin
      // deselect rewinds to the loaded byte and stays armed
      edge_cnt  <= 5'h00;
      shift_reg <= tx_hold;
      out_bit   <= low_first ? tx_hold[0] : tx_hold[7];
    end
    else if (edge_evt)
    begin
      edge_cnt <= edge_cnt + 5'h01;
      if (sample_evt)
        shift_reg <= next_shift;
      if (setup_evt)
        out_bit <= low_first ? shift_reg[0] : shift_reg[7];
      if (done_evt)
        state <= SPM_IDLE;
    end
  end

  // master clock generator
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
    begin
      div_cnt   <= 7'h00;
      sck_level <= 1'b0;
    end
    else if ((state == SPM_IDLE) | ~master)
    begin
      div_cnt   <= 7'h00;
      // follows a control write at once, so idle sck never lags the polarity bit
      sck_level <= wr_ctrl ? hwdata_in[CTRL_CPOL] : cpol;
    end
    else if (tick)
    begin
      div_cnt   <= 7'h00;
      sck_level <= ~sck_level;
    end
    else
      div_cnt <= div_cnt + 7'h01;
  end

  // receive shifter, apart from the transmit one
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
    begin
      samp_dly <= 2'h0;
      done_dly <= 2'h0;
      rx_shift <= DATA_RESET;
    end
    else
    begin
      samp_dly <= {samp_dly[0], sample_evt};
      done_dly <= {done_dly[0], done_evt};
      if (cap_evt)
        rx_shift <= next_rx;
    end
  end

  // received byte is kept only with receive enabled
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      rx_data <= DATA_RESET;
    else if (fin_evt & rx_enable)
      rx_data <= cap_evt ? next_rx : rx_shift;
  end

  // status read arms the software clearing path
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      status_seen <= 1'b0;
    else if (status_read)
      status_seen <= 1'b1;
    else if (data_access)
      status_seen <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      done_flag <= STATUS_RESET[STAT_DONE];
    else if (fin_evt | mode_fault)
      done_flag <= 1'b1;
    else if (irq_enable & irq_service_in)
      done_flag <= 1'b0;
    else if (~irq_enable & status_seen & data_access)
      done_flag <= 1'b0;
  end

  // collision: the written byte is dropped, the transfer goes on
  always_ff @(posedge clk_in or negedge rstn_sync)
  begin
    if (!rstn_sync)
      collision_flag <= STATUS_RESET[STAT_COLLISION];
    else if (wr_data & (state == SPM_SHIFT))
      collision_flag <= 1'b1;
    else if (status_seen & data_access)
      collision_flag <= 1'b0;
  end

  assign irq_request_out = done_flag & irq_enable;

  // pin drivers
  assign sck_out     = sck_level;
  assign sck_oe_out  = port_enable & master;
  assign mosi_out    = out_bit;
  assign mosi_oe_out = port_enable & master & tx_enable;
  assign miso_out    = out_bit;
  assign miso_oe_out = port_enable & slave_selected & tx_enable;
  assign ss_out      = aux[AUX_SS_OUT];
  assign ss_oe_out   = master & ss_enable & aux[AUX_SS_DIR];

endmodule // spm_port

// ### verification/spm_port_asserts.sv
// assertion checker for the serial port block
`timescale 1ns/10ps
module spm_port_asserts (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rstn_in,
  // bus and interrupt
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hready_in,
  input wire logic       hwrite_in,
  input wire logic       irq_service_in,
  input wire logic       irq_request_out,
  // pins
  input wire logic       sck_out,
  input wire logic       sck_oe_out,
  input wire logic       mosi_out,
  input wire logic       mosi_oe_out,
  input wire logic       miso_oe_out,
  input wire logic       ss_out,
  input wire logic       ss_oe_out
);
  // high during the data phase of a register write
  logic wr_phase;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      wr_phase <= 1'b0;
    else
      wr_phase <= hsel_in & htrans_in[1] & hready_in & hwrite_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sck_role_a: assert property (sck_oe_out |-> !miso_oe_out)
    else $error("miso driven while driving sck");
  slave_pins_a: assert property (miso_oe_out |-> !sck_oe_out && !mosi_oe_out && !ss_oe_out)
    else $error("slave drives a master pin");
  tx_gate_a: assert property (mosi_oe_out |-> sck_oe_out)
    else $error("mosi driven outside master role");
  irq_clear_a: assert property (irq_service_in && irq_request_out |=> !irq_request_out)
    else $error("service left the request up");
  irq_hold_a: assert property ($fell(irq_request_out) |-> $past(irq_service_in) || $past(wr_phase))
    else $error("request dropped without service");
  ss_soft_a: assert property ($changed(ss_out) |-> $past(wr_phase))
    else $error("select level moved without a write");
  sck_idle_a: assert property (!sck_oe_out && !$past(sck_oe_out) && !$past(sck_oe_out, 2)
    |-> $stable(sck_out) || $past(wr_phase))
    else $error("idle sck moved");
  // pin data may only move with an sck edge or a register write
  mosi_edge_a: assert property ($changed(mosi_out) && mosi_oe_out |-> $changed(sck_out)
    || $past(sck_out) != $past(sck_out, 2) || $past(wr_phase) || $past(wr_phase, 2))
    else $error("mosi moved off an sck edge");
  cover property ($rose(irq_request_out));
  cover property (miso_oe_out);
  cover property (sck_oe_out && $changed(sck_out));
endmodule // spm_port_asserts

bind spm_port spm_port_asserts u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
  .htrans_in(htrans_in), .hready_in(hready_in), .hwrite_in(hwrite_in), .irq_service_in(irq_service_in),
  .irq_request_out(irq_request_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .mosi_out(mosi_out),
  .mosi_oe_out(mosi_oe_out), .miso_oe_out(miso_oe_out), .ss_out(ss_out), .ss_oe_out(ss_oe_out));

// ### verification/spm_slave_model.sv
// behavioural external serial slave for master-role tests
`timescale 1ns/10ps
module spm_slave_model (
  // serial pins
  input  wire logic       sck_in,
  input  wire logic       ss_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  // setup and result
  input  wire logic       cpha_in,
  input  wire logic       lsb_first_in,
  input  wire logic [7:0] tx_byte_in,
  output logic      [7:0] rx_byte_out
);
  logic [7:0] sh;
  int         k;
  int         edges;
  initial miso_out = 1'b0;
  initial rx_byte_out = 8'h00;
  // released line shows the inverse, never a stale bit
  always @(posedge ss_n_in) miso_out <= ~miso_out;
  // selected only while its select line is low
  always @(negedge ss_n_in)
  begin
    sh = tx_byte_in;
    k = 0;
    edges = 0;
    if (!cpha_in)
      miso_out <= lsb_first_in ? sh[0] : sh[7];
  end
  // edge count, not polarity, tells leading from trailing
  always @(sck_in)
  begin
    if (!ss_n_in)
    begin
      edges++;
      if (edges[0] != cpha_in)
        rx_byte_out <= lsb_first_in ? {mosi_in, rx_byte_out[7:1]} : {rx_byte_out[6:0], mosi_in};
      else
      begin
        k = k + (cpha_in ? 0 : 1);
        if (k < 8)
          miso_out <= lsb_first_in ? sh[k] : sh[7-k];
        k = k + (cpha_in ? 1 : 0);
      end
    end
  end
endmodule // spm_slave_model

// ### verification/tb_top.sv
// self-checking bench for the serial port block
`timescale 1ns/10ps
module tb_top;
  import spm_pkg::*;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        irq_svc = 1'b0;
  logic        tb_sck = 1'b0;
  logic        tb_mosi = 1'b0;
  logic        tb_ss = 1'b1;
  logic        m_cpha = 1'b0;
  logic        m_lsb = 1'b0;
  logic [7:0]  m_tx = 8'h00;
  logic [7:0]  m_rx;
  logic [31:0] hrdata;
  logic        hready, hresp, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, m_miso;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  wire         w_sck  = sck_oe ? sck_o : tb_sck;
  wire         w_mosi = mosi_oe ? mosi_o : tb_mosi;
  wire         w_miso = miso_oe ? miso_o : m_miso;
  wire         w_ss   = ss_oe ? ss_o : tb_ss;
  always #20 clk_in = ~clk_in;
  spm_port uut (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .irq_service_in(irq_svc), .irq_request_out(irq),
    .sck_in(w_sck), .sck_out(sck_o), .sck_oe_out(sck_oe), .mosi_in(w_mosi), .mosi_out(mosi_o),
    .mosi_oe_out(mosi_oe), .miso_in(w_miso), .miso_out(miso_o), .miso_oe_out(miso_oe), .ss_in(w_ss),
    .ss_out(ss_o), .ss_oe_out(ss_oe));
  spm_slave_model partner (.sck_in(w_sck), .ss_n_in(w_ss | ~ss_oe), .mosi_in(w_mosi), .miso_out(m_miso),
    .cpha_in(m_cpha), .lsb_first_in(m_lsb), .tx_byte_in(m_tx), .rx_byte_out(m_rx));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // single transfer; data phase ends at the second ready edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk_in); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  // status polls; the last one read leaves done set
  task automatic wait_done(output logic [31:0] st);
    int k;
    k = 0;
    do bus(STATUS_ADDR, 1'b0, 8'h00, st); while (st[STAT_DONE] !== 1'b1 && ++k < 1000);
  endtask
  task automatic t_reset;
    logic [31:0] r;
    logic [31:0] a[5] = '{CTRL_ADDR, DATA_ADDR, STATUS_ADDR, AUX_ADDR, 32'h0000_0360};
    wr(32'h0000_0360, 8'hFF);
    foreach (a[i])
    begin
      bus(a[i], 1'b0, 8'h00, r);
      chk(r, 32'h0);
    end
    chk({sck_oe, mosi_oe, miso_oe, ss_oe}, 4'h0);
  endtask
  task automatic t_master;
    int          div[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    logic [31:0] r, st;
    logic [7:0]  c;
    int          n;
    wr(STATUS_ADDR, 8'h07);
    for (int i = 0; i < 8; i++)
    begin
      c = {1'b1, i[2], 1'b1, i[1], i[0], i[2:0]};
      m_cpha <= i[0];
      m_lsb <= i[2];
      m_tx <= ~c;
      wr(AUX_ADDR, 8'h06);
      wr(CTRL_ADDR, c);
      @(posedge clk_in);
      chk(sck_o, c[CTRL_CPOL]);
      wr(AUX_ADDR, 8'h02);
      @(posedge clk_in);
      chk(w_ss, 1'b0);
      wr(DATA_ADDR, 8'h5A ^ c);
      n = 0;
      while (sck_o === c[CTRL_CPOL] && n < 300)
      begin
        @(posedge clk_in);
        n++;
      end
      n = 0;
      do begin @(posedge clk_in); n++; end while (sck_o !== c[CTRL_CPOL] && n < 300);
      chk(n, div[i] / 2);
      if (i == 1)
        wr(DATA_ADDR, 8'hFF);
      wait_done(st);
      chk(st[STAT_COLLISION], i == 1);
      bus(STATUS_ADDR, 1'b0, 8'h00, st);
      chk(st[STAT_DONE], 1'b1);
      bus(DATA_ADDR, 1'b0, 8'h00, r);
      chk(r, {24'h0, ~c});
      chk(m_rx, 8'h5A ^ c);
      bus(STATUS_ADDR, 1'b0, 8'h00, st);
      chk(st[STAT_DONE], 1'b0);
    end
  endtask
  task automatic t_irq;
    logic [31:0] r;
    int          n;
    wr(AUX_ADDR, 8'h03);
    wr(DATA_ADDR, 8'h81);
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk_in);
      n++;
    end
    bus(STATUS_ADDR, 1'b0, 8'h00, r);
    bus(DATA_ADDR, 1'b0, 8'h00, r);
    chk(irq, 1'b1);
    irq_svc <= 1'b1;
    @(posedge clk_in);
    irq_svc <= 1'b0;
    @(posedge clk_in);
    chk(irq, 1'b0);
  endtask
  task automatic t_fault;
    logic [31:0] r;
    // drive select high first, so the switch to input shows no low glitch
    wr(AUX_ADDR, 8'h06);
    repeat (4) @(posedge clk_in);
    wr(AUX_ADDR, 8'h00);
    repeat (8) @(posedge clk_in);
    bus(CTRL_ADDR, 1'b0, 8'h00, r);
    chk(r[CTRL_MASTER], 1'b1);
    tb_ss <= 1'b0;
    repeat (8) @(posedge clk_in);
    bus(CTRL_ADDR, 1'b0, 8'h00, r);
    chk(r[CTRL_MASTER], 1'b0);
    bus(STATUS_ADDR, 1'b0, 8'h00, r);
    chk(r[STAT_DONE], 1'b1);
    bus(DATA_ADDR, 1'b0, 8'h00, r);
    tb_ss <= 1'b1;
  endtask
  // bench as master; sck stands still outside the frame
  task automatic sbyte(input logic [7:0] mo, input int nb, output logic [7:0] mi);
    tb_ss <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int b = 7; b > 7 - nb; b--)
    begin
      tb_mosi <= mo[b];
      repeat (4) @(posedge clk_in);
      mi[b] = w_miso;
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk_in);
      tb_sck <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    tb_ss <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic t_slave;
    logic [31:0] r;
    logic [7:0]  mi;
    wr(STATUS_ADDR, 8'h07);
    wr(CTRL_ADDR, 8'h80);
    wr(DATA_ADDR, 8'hC3);
    sbyte(8'h96, 3, mi);
    bus(STATUS_ADDR, 1'b0, 8'h00, r);
    chk(r[STAT_DONE], 1'b0);
    chk(r[STAT_SS_HIGH], 1'b1);
    wr(STATUS_ADDR, 8'h07);
    bus(STATUS_ADDR, 1'b0, 8'h00, r);
    chk(r[STAT_SS_HIGH], 1'b0);
    sbyte(8'h96, 8, mi);
    chk(mi, 8'hC3);
    bus(STATUS_ADDR, 1'b0, 8'h00, r);
    chk(r[STAT_DONE], 1'b1);
    bus(DATA_ADDR, 1'b0, 8'h00, r);
    chk(r, 32'h0000_0096);
  endtask
  task automatic t_gate;
    logic [31:0] r;
    wr(STATUS_ADDR, 8'h05);
    wr(CTRL_ADDR, 8'h20);
    wr(DATA_ADDR, 8'h11);
    repeat (100) @(posedge clk_in);
    chk(sck_oe, 1'b0);
    wr(CTRL_ADDR, 8'hA0);
    @(posedge clk_in);
    chk({sck_oe, mosi_oe}, 2'b10);
    repeat (100) @(posedge clk_in);
    bus(STATUS_ADDR, 1'b0, 8'h00, r);
    chk(r[STAT_DONE], 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_master();
    t_irq();
    t_fault();
    t_slave();
    t_gate();
    finish_test();
  end
endmodule // tb_top
